// ===== inc/dtec_pkg.sv
// Package for the dual timer/event counter: constants, modes and carriers
//==========================================================================
// Contract
// - Two independent 8-bit up counters, step one.
// - Modes: interval timer, event counter, pulse capture.
// - Timer and capture modes use internal clock.
// - Counter0 sysclk/crystal; counter1 sysclk/4 or crystal.
// - Counter0 internal clock passes 3-bit prescaler.
// - Event mode counts chosen edge on pin.
// - Increment past full scale raises overflow request.
// - Overflow reloads preload value, keeps counting.
// - Preload registers power up unknown, unreset.
// - Preload write while stopped loads counter too.
// - Preload write while running waits for reload.
// - Counter value output shows live count.
// - PWM enabled forces counter0 source to sysclk.
// - Prescaler divides by two to field power.
// - Mode field: none, event, timer, capture.
// - Edge select: 0 rising, 1 falling.
// - Run enable 1 counts, 0 holds.
//==========================================================================
package dtec_pkg;

  // Counter geometry
  localparam int          DTEC_NCH       = 2;      // Number of counters
  localparam int          DTEC_CNT_W     = 8;      // Counter width
  localparam int          DTEC_PSC_W     = 3;      // Prescaler field width

  // Counter values
  localparam logic [7:0]  DTEC_CNT_FULL  = 8'hff;  // Full scale
  localparam logic [7:0]  DTEC_CNT_RST   = 8'h00;  // Count after reset
  localparam logic [7:0]  DTEC_CNT_STEP  = 8'h01;  // Increment

  // Instruction clock divider for counter 1
  localparam logic [1:0]  DTEC_DIV4_RST  = 2'h0;
  localparam logic [1:0]  DTEC_DIV4_LAST = 2'h3;
  localparam logic [1:0]  DTEC_DIV4_STEP = 2'h1;

  // Mode field encoding
  typedef enum logic [1:0] {
    DTEC_MODE_NONE    = 2'h0,
    DTEC_MODE_EVENT   = 2'h1,
    DTEC_MODE_TIMER   = 2'h2,
    DTEC_MODE_CAPTURE = 2'h3
  } dtec_mode_t;

  // Per-counter control bits
  typedef struct packed {
    dtec_mode_t                operating_mode_field;
    logic                      clock_source_select;
    logic                      active_edge_select;
    logic                      counter_run_enable;
    logic [DTEC_PSC_W-1:0]     counter0_prescale_field;
  } dtec_ctrl_t;

  // Preload write strobe with its data
  typedef struct packed {
    logic                      wr;
    logic [DTEC_CNT_W-1:0]     data;
  } dtec_preload_wr_t;

endpackage

// ===== src/dtec_edge_detect.sv
// Edge detector for a level that is synchronous to the clock
`timescale 1ns/1ps
`default_nettype none

module dtec_edge_detect
(
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic level,
  output logic      rise,
  output logic      fall
);

  //==========================================================================
  // State
  //==========================================================================
  logic prev;       // Level one cycle ago
  logic armed;      // Set once prev holds a real sample
  logic next_prev;
  logic next_armed;

  // Next state: armed avoids a false edge from the reset value of prev
  always_comb
  begin
    next_prev  = level;
    next_armed = 1'b1;
  end

  // Register only
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      prev  <= 1'b0;
      armed <= 1'b0;
    end
    else
    begin
      prev  <= next_prev;
      armed <= next_armed;
    end
  end

  // Edge pulses, one cycle each
  assign rise = armed & level & ~prev;
  assign fall = armed & ~level & prev;

endmodule

`default_nettype wire

// ===== src/dtec_prescaler.sv
// Power-of-two prescaler for a stream of clock ticks
`timescale 1ns/1ps
`default_nettype none

module dtec_prescaler
#(
  parameter int PSC_W = dtec_pkg::DTEC_PSC_W
)
(
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic             tick_in,
  input  wire logic [PSC_W-1:0] rate,
  output logic                  tick_out
);

  //==========================================================================
  // Divider chain
  //==========================================================================
  localparam int CW = (2 ** PSC_W) - 1;  // Bits for the largest ratio

  logic [CW-1:0] cnt;       // Ticks seen so far
  logic [CW-1:0] next_cnt;
  logic [CW-1:0] mask;      // Low bits that must be all ones

  // Next count; rate 0 gives an empty mask and passes every tick
  always_comb
  begin
    mask     = ~({CW{1'b1}} << rate);
    next_cnt = tick_in ? cnt + CW'(1) : cnt;
  end

  // Register only
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      cnt <= '0;
    else
      cnt <= next_cnt;
  end

  // One tick out per 2^rate ticks in
  assign tick_out = tick_in & ((cnt & mask) == mask);

endmodule

`default_nettype wire

// ===== src/dtec_top.sv
// Dual 8-bit timer/event counter with preload and overflow requests
`timescale 1ns/1ps
`default_nettype none

module dtec_top
(
  input  wire logic                                   clk,
  input  wire logic                                   rstn,
  input  wire dtec_pkg::dtec_ctrl_t [1:0]             counter_control,
  input  wire dtec_pkg::dtec_preload_wr_t [1:0]       preload_write,
  input  wire logic                                   pwm_enable,
  input  wire logic                                   low_freq_crystal_clock,
  input  wire logic [1:0]                             external_count_pin,
  output logic [dtec_pkg::DTEC_CNT_W-1:0]             counter0_value,
  output logic [dtec_pkg::DTEC_CNT_W-1:0]             counter1_value,
  output logic [1:0]                                  overflow_irq
);

  //==========================================================================
  // Declarations
  //==========================================================================
  localparam int NCH = dtec_pkg::DTEC_NCH;
  localparam int CW  = dtec_pkg::DTEC_CNT_W;

  logic [CW-1:0]  cnt          [NCH];  // Live counts
  logic [CW-1:0]  next_cnt     [NCH];
  logic [CW-1:0]  preload      [NCH];  // Reload values, no reset
  logic [CW-1:0]  next_preload [NCH];
  logic [NCH-1:0] ovf;                 // Registered overflow pulses
  logic [NCH-1:0] next_ovf;
  logic [NCH-1:0] adv;                 // Counter advances this cycle
  logic [NCH-1:0] int_tick;            // Internal clock ticks per counter
  logic [NCH-1:0] pin_rise;            // Pin edges
  logic [NCH-1:0] pin_fall;
  logic           xtal_fall;           // Crystal high-to-low transition
  logic           src0_xtal;           // Counter 0 runs from the crystal
  logic           src0_tick;           // Counter 0 source before prescaler
  logic [1:0]     div4;                // Instruction clock divider
  logic [1:0]     next_div4;
  logic           sys4_tick;           // One tick per four system clocks

  //==========================================================================
  // Edge detection on the crystal and the count pins
  //==========================================================================
  // The crystal is far slower than clk, so its edges arrive as ticks
  dtec_edge_detect u_xtal_edge
  (
    .clk   (clk),
    .rstn  (rstn),
    .level (low_freq_crystal_clock),
    .rise  (),
    .fall  (xtal_fall)
  );

  // One detector per counter pin
  for (genvar g = 0; g < NCH; g++)
  begin : g_pin
    dtec_edge_detect u_pin_edge
    (
      .clk   (clk),
      .rstn  (rstn),
      .level (external_count_pin[g]),
      .rise  (pin_rise[g]),
      .fall  (pin_fall[g])
    );
  end

  //==========================================================================
  // Internal clock sources
  //==========================================================================
  // Counter 0: PWM on forces the system clock, hiding the select bit
  assign src0_xtal = counter_control[0].clock_source_select & ~pwm_enable;
  assign src0_tick = src0_xtal ? xtal_fall : 1'b1;

  // Counter 0 prescaler; ignored in event mode, which takes pin edges
  dtec_prescaler #(.PSC_W(dtec_pkg::DTEC_PSC_W)) u_psc0
  (
    .clk      (clk),
    .rstn     (rstn),
    .tick_in  (src0_tick),
    .rate     (counter_control[0].counter0_prescale_field),
    .tick_out (int_tick[0])
  );

  // Instruction clock divider, free running
  // Not cleared on mode or select changes: the first interval after a
  // start may be short by up to three clocks, a limitation users must allow
  always_comb
  begin
    next_div4 = div4 + dtec_pkg::DTEC_DIV4_STEP;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      div4 <= dtec_pkg::DTEC_DIV4_RST;
    else
      div4 <= next_div4;
  end

  assign sys4_tick = (div4 == dtec_pkg::DTEC_DIV4_LAST);

  // Counter 1: instruction clock or crystal, no prescaler
  assign int_tick[1] = counter_control[1].clock_source_select ? xtal_fall
                                                              : sys4_tick;

  //==========================================================================
  // Advance qualification per counter
  //==========================================================================
  // Mode decides where counting pulses come from; run enable gates all
  // Capture reads the raw pin level, so a width is counted in ticks
  always_comb
  begin
    for (int i = 0; i < NCH; i++)
    begin
      case (counter_control[i].operating_mode_field)
        dtec_pkg::DTEC_MODE_EVENT:
          // Edge select 0 counts rising, 1 counts falling
          adv[i] = counter_control[i].active_edge_select ? pin_fall[i]
                                                         : pin_rise[i];
        dtec_pkg::DTEC_MODE_TIMER:
          adv[i] = int_tick[i];
        dtec_pkg::DTEC_MODE_CAPTURE:
          // Counts only during the pulse; the closing edge stops it
          adv[i] = int_tick[i] &
                   (external_count_pin[i] == counter_control[i].active_edge_select);
        default:
          adv[i] = 1'b0;
      endcase
      adv[i] = adv[i] & counter_control[i].counter_run_enable;
    end
  end

  //==========================================================================
  // Count, preload and overflow next values
  //==========================================================================
  // A running write reaches the counter only through the next reload
  always_comb
  begin
    for (int i = 0; i < NCH; i++)
    begin
      next_preload[i] = preload_write[i].wr ? preload_write[i].data
                                            : preload[i];
      next_cnt[i]     = cnt[i];
      next_ovf[i]     = 1'b0;
      if (preload_write[i].wr && !counter_control[i].counter_run_enable)
      begin
        // Stopped counter takes the written value at once
        next_cnt[i] = preload_write[i].data;
      end
      else if (adv[i])
      begin
        if (cnt[i] == dtec_pkg::DTEC_CNT_FULL)
        begin
          // Wrap: reload and request; a same-cycle write is the new preload
          next_cnt[i] = next_preload[i];
          next_ovf[i] = 1'b1;
        end
        else
        begin
          next_cnt[i] = cnt[i] + dtec_pkg::DTEC_CNT_STEP;
        end
      end
    end
  end

  // Counters and overflow pulses reset to defined values
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      for (int i = 0; i < NCH; i++)
        cnt[i] <= dtec_pkg::DTEC_CNT_RST;
      ovf <= '0;
    end
    else
    begin
      for (int i = 0; i < NCH; i++)
        cnt[i] <= next_cnt[i];
      ovf <= next_ovf;
    end
  end

  // Preload carries no reset: it is unknown until software writes it
  always_ff @(posedge clk)
  begin
    for (int i = 0; i < NCH; i++)
      preload[i] <= next_preload[i];
  end

  //==========================================================================
  // Outputs
  //==========================================================================
  assign counter0_value = cnt[0];
  assign counter1_value = cnt[1];
  assign overflow_irq   = ovf;

  //==========================================================================
  // Assertions
  //==========================================================================
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  // PWM or select 0 with ratio 0: counter 0 sees a tick every clock
  a_pwm_src_force: assert property (
    (pwm_enable || !counter_control[0].clock_source_select) &&
    (counter_control[0].counter0_prescale_field == '0) |-> int_tick[0])
    else $error("counter 0 internal tick missing with system clock source");

  // Instruction clock: a tick, three quiet cycles, then the next tick
  a_div4_spacing: assert property (
    sys4_tick |=> !sys4_tick [*3] ##1 sys4_tick)
    else $error("counter 1 instruction clock spacing wrong");

  // Crystal-fed counter 1 advances only where the crystal level falls
  a_xtal1_fall: assert property (
    counter_control[1].clock_source_select && adv[1] &&
    counter_control[1].operating_mode_field == dtec_pkg::DTEC_MODE_TIMER |->
    $past(low_freq_crystal_clock) && !low_freq_crystal_clock)
    else $error("counter 1 advanced off a crystal fall");

  for (genvar g = 0; g < NCH; g++)
  begin : g_chk
    // Overflow pulse only follows an advance at full scale
    a_ovf_cause: assert property (
      ovf[g] |-> $past(adv[g] && cnt[g] == dtec_pkg::DTEC_CNT_FULL &&
                       !(preload_write[g].wr &&
                         !counter_control[g].counter_run_enable)))
      else $error("overflow pulse without a full-scale advance");

    // After the wrap the count equals the preload register
    a_ovf_reload: assert property (
      adv[g] && cnt[g] == dtec_pkg::DTEC_CNT_FULL |=>
      ovf[g] && cnt[g] == preload[g])
      else $error("counter not reloaded from preload on overflow");

    // Below full scale an advance adds exactly one
    a_step_one: assert property (
      adv[g] && cnt[g] != dtec_pkg::DTEC_CNT_FULL |=>
      cnt[g] == $past(cnt[g]) + dtec_pkg::DTEC_CNT_STEP && !ovf[g])
      else $error("counter did not step by one");

    // Stopped and not written: count holds
    a_hold_stopped: assert property (
      !counter_control[g].counter_run_enable && !preload_write[g].wr |=>
      cnt[g] == $past(cnt[g]))
      else $error("stopped counter changed");

    // Write while stopped lands in both preload and count
    a_wr_stopped: assert property (
      preload_write[g].wr && !counter_control[g].counter_run_enable |=>
      cnt[g] == $past(preload_write[g].data) &&
      preload[g] == $past(preload_write[g].data))
      else $error("stopped write not loaded into counter");

    // Write while running, in a cycle with no advance, leaves the count alone
    a_wr_running: assert property (
      preload_write[g].wr && counter_control[g].counter_run_enable &&
      !adv[g] |=> cnt[g] == $past(cnt[g]) &&
      preload[g] == $past(preload_write[g].data))
      else $error("running write disturbed the counter");

    // Event mode advances on exactly the selected pin edge, judged from the pin
    a_event_edge: assert property (
      counter_control[g].counter_run_enable &&
      counter_control[g].operating_mode_field == dtec_pkg::DTEC_MODE_EVENT |->
      adv[g] == (counter_control[g].active_edge_select
                 ? ($past(external_count_pin[g]) && !external_count_pin[g])
                 : (!$past(external_count_pin[g]) && external_count_pin[g])))
      else $error("event mode advanced on the wrong edge");

    // Timer mode advances on the internal tick
    a_timer_src: assert property (
      counter_control[g].counter_run_enable &&
      counter_control[g].operating_mode_field == dtec_pkg::DTEC_MODE_TIMER |->
      adv[g] == int_tick[g])
      else $error("timer mode not on internal clock");

    // Capture mode is quiet while the pin is outside its active level
    a_capture_gate: assert property (
      counter_control[g].operating_mode_field == dtec_pkg::DTEC_MODE_CAPTURE &&
      external_count_pin[g] != counter_control[g].active_edge_select |->
      !adv[g])
      else $error("capture counted outside the pulse");

    // No mode: never advances
    a_none_idle: assert property (
      counter_control[g].operating_mode_field == dtec_pkg::DTEC_MODE_NONE |->
      !adv[g])
      else $error("counter advanced with no mode");

    // Main scenarios
    c_ovf_timer: cover property (
      counter_control[g].operating_mode_field == dtec_pkg::DTEC_MODE_TIMER &&
      ovf[g]);
    c_ovf_event: cover property (
      counter_control[g].operating_mode_field == dtec_pkg::DTEC_MODE_EVENT &&
      ovf[g]);
    c_capture_run: cover property (
      counter_control[g].operating_mode_field == dtec_pkg::DTEC_MODE_CAPTURE &&
      adv[g] ##1 !adv[g]);
    c_wr_running: cover property (
      preload_write[g].wr && counter_control[g].counter_run_enable);
  end

endmodule

`default_nettype wire

// ===== dv/dtec_pin_model.sv
// Pulse source standing on an external count pin of the counter block
`timescale 1ns/1ps
`default_nettype none

module dtec_pin_model
(
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       go,
  input  wire logic       idle_lvl,
  input  wire logic [7:0] width,
  output logic            pin,
  output logic            busy
);
  //==========================================================
  // Pulse timing
  logic [7:0] left;  // Cycles of active level still to drive

  // Load the width on a start strobe, then count it down
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      left <= 8'h00;
    end
    else if (go)
    begin
      left <= width;
    end
    else if (left != 8'h00)
    begin
      left <= left - 8'h01;
    end
  end

  // Pin changes just after an edge, so it is synchronous like a real synced pin
  assign busy = (left != 8'h00);
  assign pin  = busy ? ~idle_lvl : idle_lvl;
endmodule

`default_nettype wire

// ===== dv/tb_top.sv
// Self-checking bench for the dual timer/event counter
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) \
  begin \
    checks_done++; \
    if ((g) !== (e)) \
    begin \
      errors++; \
      $display("[FAIL] %s exp %h got %h", nm, e, g); \
    end \
  end

module tb_top;
  //==========================================================
  // Stimulus and observed signals
  logic                             clk;          // 25 MHz system clock
  logic                             rstn;         // Async reset, low active
  dtec_pkg::dtec_ctrl_t [1:0]       ctl;          // Control bits per counter
  dtec_pkg::dtec_preload_wr_t [1:0] pw;           // Preload strobes
  logic                             pwm;          // Modulator enable
  logic                             xtal;         // Slow crystal level
  logic [1:0]                       pin;          // Pins from the models
  logic [1:0]                       go;           // Pulse start strobes
  logic [1:0]                       busy;         // Models still pulsing
  logic [1:0]                       idle;         // Idle level per pin
  logic [7:0]                       wid;          // Pulse width to send
  logic [7:0]                       c0;           // Live count 0
  logic [7:0]                       c1;           // Live count 1
  logic [1:0]                       irq;          // Overflow pulses
  int                               errors;       // Mismatch count
  int                               checks_done;  // Comparison count
  int                               xc;           // Crystal half period

  //==========================================================
  // Clock, crystal and instances
  always #20 clk = ~clk;

  // Crystal period of ten system cycles, far slower than the clock
  always @(posedge clk)
  begin
    xc <= (xc == 4) ? 0 : xc + 1;
    if (xc == 4)
    begin
      xtal <= ~xtal;
    end
  end

  for (genvar g = 0; g < 2; g++)
  begin : g_pin
    dtec_pin_model pin_u (.clk(clk), .rstn(rstn), .go(go[g]), .idle_lvl(idle[g]),
                          .width(wid), .pin(pin[g]), .busy(busy[g]));
  end

  dtec_top dut_u (.clk(clk), .rstn(rstn), .counter_control(ctl), .preload_write(pw),
                  .pwm_enable(pwm), .low_freq_crystal_clock(xtal),
                  .external_count_pin(pin), .counter0_value(c0), .counter1_value(c1),
                  .overflow_irq(irq));

  //==========================================================
  // Shared helpers
  function automatic logic [7:0] cnt(int i);
    return (i == 0) ? c0 : c1;
  endfunction

  task automatic close_out();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Control word lands at the next rising edge
  task automatic ctl_set(int i, dtec_pkg::dtec_mode_t m, logic s, logic e, logic r,
                         logic [2:0] p);
    @(posedge clk);
    ctl[i] <= {m, s, e, r, p};
  endtask

  // One-cycle preload strobe
  task automatic wr(int i, logic [7:0] d);
    @(posedge clk);
    pw[i] <= {1'b1, d};
    @(posedge clk);
    pw[i].wr <= 1'b0;
  endtask

  // Stop, clear the count through a stopped write, then run
  task automatic arm(int i, dtec_pkg::dtec_mode_t m, logic s, logic e, logic [2:0] p);
    ctl_set(i, m, s, e, 1'b0, p);
    wr(i, 8'h00);
    ctl_set(i, m, s, e, 1'b1, p);
  endtask

  // Advances seen over n cycles
  task automatic rate(int i, int n, int e, string nm);
    logic [7:0] a;
    @(negedge clk);
    a = cnt(i);
    repeat (n) @(negedge clk);
    `CHK(nm, 8'(e), 8'(cnt(i) - a))
  endtask

  // Bounded wait for a pin pulse to finish
  task automatic pulse(int i, logic [7:0] w);
    int k;
    @(posedge clk);
    wid   <= w;
    go[i] <= 1'b1;
    @(posedge clk);
    go[i] <= 1'b0;
    @(negedge clk);
    for (k = 0; k < 300 && busy[i]; k++) @(negedge clk);
    if (busy[i] !== 1'b0)
    begin
      errors++;
      $display("[FAIL] pulse wait exp 0 got 1");
      close_out();
    end
    repeat (3) @(negedge clk);
  endtask

  //==========================================================
  // Scenarios
  task automatic t_load();
    for (int i = 0; i < 2; i++)
    begin
      ctl_set(i, dtec_pkg::DTEC_MODE_TIMER, 1'b0, 1'b0, 1'b0, 3'h0);
      wr(i, 8'h3c + 8'(i));
      @(negedge clk);
      `CHK("stopped load", 8'h3c + 8'(i), cnt(i))
    end
    $display("test load done");
  endtask

  // Running write waits for the reload; overflow pulses once
  task automatic t_walk();
    ctl_set(0, dtec_pkg::DTEC_MODE_TIMER, 1'b0, 1'b0, 1'b0, 3'h0);
    wr(0, 8'hfd);
    ctl_set(0, dtec_pkg::DTEC_MODE_TIMER, 1'b0, 1'b0, 1'b1, 3'h0);
    wr(0, 8'h5a);
    @(negedge clk);
    `CHK("running write", 8'hff, c0)
    @(negedge clk);
    `CHK("reload value", 8'h5a, c0)
    `CHK("overflow pulse", 2'b01, irq)
    @(negedge clk);
    `CHK("pulse length", 2'b00, irq)
    `CHK("after reload", 8'h5b, c0)
    $display("test walk done");
  endtask

  // Zero preload gives the full 256-step range
  task automatic t_full();
    int n;
    arm(0, dtec_pkg::DTEC_MODE_TIMER, 1'b0, 1'b0, 3'h0);
    // Run bit lands at this edge; the first advance comes one edge later
    @(negedge clk);
    n = 0;
    for (int k = 0; k < 300 && irq[0] !== 1'b1; k++)
    begin
      @(negedge clk);
      n++;
    end
    `CHK("full range", 256, n)
    if (irq[0] !== 1'b1)
      close_out();
    `CHK("zero reload", 8'h00, c0)
    $display("test full done");
  endtask

  // Every prescaler ratio, the divide-by-four path, no mode and stop
  task automatic t_rates();
    for (int p = 0; p < 8; p++)
    begin
      arm(0, dtec_pkg::DTEC_MODE_TIMER, 1'b0, 1'b0, 3'(p));
      rate(0, 128, 128 >> p, "prescale");
    end
    arm(1, dtec_pkg::DTEC_MODE_TIMER, 1'b0, 1'b0, 3'h0);
    rate(1, 128, 32, "div four");
    arm(0, dtec_pkg::DTEC_MODE_NONE, 1'b0, 1'b0, 3'h0);
    rate(0, 64, 0, "no mode");
    ctl_set(1, dtec_pkg::DTEC_MODE_TIMER, 1'b0, 1'b0, 1'b0, 3'h0);
    rate(1, 64, 0, "stopped");
    $display("test rates done");
  endtask

  // Crystal source on both counters, and the modulator override
  task automatic t_xtal();
    for (int i = 0; i < 2; i++)
    begin
      arm(i, dtec_pkg::DTEC_MODE_TIMER, 1'b1, 1'b0, 3'h0);
      rate(i, 100, 10, "crystal");
    end
    @(posedge clk);
    pwm <= 1'b1;
    arm(0, dtec_pkg::DTEC_MODE_TIMER, 1'b1, 1'b0, 3'h0);
    rate(0, 100, 100, "pwm override");
    @(posedge clk);
    pwm <= 1'b0;
    $display("test xtal done");
  endtask

  // Edge counting on the pin, held while stopped
  task automatic t_event();
    ctl_set(1, dtec_pkg::DTEC_MODE_EVENT, 1'b0, 1'b0, 1'b0, 3'h0);
    wr(1, 8'h00);
    pulse(1, 8'h04);
    `CHK("event stopped", 8'h00, c1)
    for (int e = 0; e < 2; e++)
    begin
      ctl_set(1, dtec_pkg::DTEC_MODE_EVENT, 1'b0, 1'(e), 1'b1, 3'h0);
      repeat (3) pulse(1, 8'h04);
      `CHK("event edges", 8'(3 * (e + 1)), c1)
    end
    $display("test event done");
  endtask

  // Pulse width capture at both active levels
  task automatic t_cap();
    arm(0, dtec_pkg::DTEC_MODE_CAPTURE, 1'b0, 1'b1, 3'h0);
    pulse(0, 8'h14);
    `CHK("high width", 8'h14, c0)
    ctl_set(0, dtec_pkg::DTEC_MODE_CAPTURE, 1'b0, 1'b0, 1'b0, 3'h0);
    @(posedge clk);
    idle[0] <= 1'b1;
    arm(0, dtec_pkg::DTEC_MODE_CAPTURE, 1'b0, 1'b0, 3'h0);
    pulse(0, 8'h0c);
    `CHK("low width", 8'h0c, c0)
    $display("test capture done");
  endtask

  //==========================================================
  // Main sequence
  initial
  begin
    clk         = 1'b0;
    rstn        = 1'b0;
    ctl         = '0;
    pw          = '0;
    pwm         = 1'b0;
    xtal        = 1'b0;
    go          = 2'b00;
    idle        = 2'b00;
    wid         = 8'h00;
    xc          = 0;
    errors      = 0;
    checks_done = 0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    t_load();
    t_walk();
    t_full();
    t_rates();
    t_xtal();
    t_event();
    t_cap();
    close_out();
  end
endmodule

`default_nettype wire
